// ==== sdi_io_pkg.sv ====
package sdi_io_pkg;

  // Timing
  localparam int CLK_PERIOD_NS       = 8;
  localparam int SLEEP_MAX_NS        = 200000;
  localparam int SLEEP_MAX_CYCLES    = SLEEP_MAX_NS / CLK_PERIOD_NS;
  // Half the ceiling leaves margin for the input synchronisers
  localparam int SLEEP_DELAY_DEFAULT = SLEEP_MAX_CYCLES / 2;

  // Frame layout
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 5;
  localparam logic [CNT_W-1:0] LAST_HEADER_BIT = 5'h07;
  localparam logic [CNT_W-1:0] LAST_FRAME_BIT  = 5'h0F;
  localparam logic [CNT_W-1:0] READ_END_COUNT  = 5'h10;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_GENERAL_CONTROL = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_DRIVER   = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_LAUNCH_AMPL     = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_CABLE_LENGTH    = 7'h03;

  // General control fields
  localparam int CARRIER_BIT   = 7;
  localparam int MUTE_BIT      = 6;
  localparam int EXT_REACH_BIT = 5;
  localparam int SLEEP_MSB     = 4;
  localparam int SLEEP_LSB     = 3;
  localparam logic [DATA_W-1:0] GENERAL_CONTROL_WMASK = 8'h78;

  // Output driver, launch amplitude and cable length fields
  localparam int SWING_MSB  = 7;
  localparam int SWING_LSB  = 5;
  localparam int OFFSET_MSB = 4;
  localparam int OFFSET_LSB = 2;
  localparam int COARSE_BIT = 7;
  localparam int FINE_MSB   = 6;
  localparam int FINE_LSB   = 3;
  localparam int CLI_W      = 5;

  // Reset values
  localparam logic [DATA_W-1:0] GENERAL_CONTROL_RESET = 8'h08;
  localparam logic [DATA_W-1:0] OUTPUT_DRIVER_RESET   = 8'h64;
  localparam logic [DATA_W-1:0] LAUNCH_AMPL_RESET     = 8'h00;

  typedef enum logic [1:0] {
    SLEEP_NEVER  = 2'b00,
    SLEEP_AUTO   = 2'b01,
    SLEEP_FORCED = 2'b10,
    SLEEP_RSVD   = 2'b11
  } sleep_mode_t;

  typedef enum logic [2:0] {
    SPI_IDLE   = 3'b000,
    SPI_HEADER = 3'b001,
    SPI_WRITE  = 3'b010,
    SPI_READ   = 3'b011,
    SPI_WAIT   = 3'b100
  } spi_state_t;

endpackage : sdi_io_pkg

// ==== sync_2ff.sv ====
`timescale 1ns/1ps
module sync_2ff #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : sync_2ff

// ==== sleep_control.sv ====
`timescale 1ns/1ps
module sleep_control #(
  parameter int DELAY_CYCLES = sdi_io_pkg::SLEEP_DELAY_DEFAULT
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  // Control
  input  wire logic [1:0] mode_i,
  input  wire logic       carrier_i,
  // Status
  output logic            sleep_o
);

  localparam int DW = $clog2(DELAY_CYCLES + 1);
  localparam logic [DW-1:0] LAST = DW'(DELAY_CYCLES - 1);

  logic [DW-1:0] lost_cnt_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lost_cnt_reg <= '0;
    end else if (carrier_i || mode_i == sdi_io_pkg::SLEEP_NEVER || mode_i == sdi_io_pkg::SLEEP_FORCED) begin
      // Reserved code keeps counting, so it behaves as auto
      lost_cnt_reg <= '0;
    end else if (lost_cnt_reg != LAST) begin
      lost_cnt_reg <= lost_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_o <= 1'b0;
    end else begin
      unique case (mode_i)
        sdi_io_pkg::SLEEP_NEVER:  sleep_o <= 1'b0;
        sdi_io_pkg::SLEEP_FORCED: sleep_o <= 1'b1;
        // Wake is immediate; power-down waits out the dwell
        default: sleep_o <= !carrier_i && (lost_cnt_reg == LAST);
      endcase
    end
  end

endmodule : sleep_control

// ==== sdi_io_serial_control.sv ====
`timescale 1ns/1ps
module sdi_io_serial_control #(
  parameter int SLEEP_DELAY_CYCLES = sdi_io_pkg::SLEEP_DELAY_DEFAULT
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  // Serial port pins
  input  wire logic       sck_i,
  input  wire logic       ss_n_i,
  input  wire logic       mosi_i,
  input  wire logic       spi_enable_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  // Mode pin
  input  wire logic       tx_enable_i,
  output logic            cable_driver_enable_o,
  // Analog front end status
  input  wire logic       signal_detect_i,
  input  wire logic [4:0] cable_length_i,
  input  wire logic       equalizer_data_i,
  // Carrier and equalizer outputs
  output logic            carrier_present_n_o,
  output logic            equalizer_sleep_o,
  output logic            equalized_out_p_o,
  output logic            equalized_out_n_o,
  // Analog settings
  output logic            extended_reach_o,
  output logic [2:0]      output_swing_o,
  output logic [2:0]      output_offset_o,
  output logic            launch_coarse_o,
  output logic [3:0]      launch_fine_o
);

  localparam int AW = sdi_io_pkg::ADDR_W;
  localparam int DW = sdi_io_pkg::DATA_W;
  localparam int CW = sdi_io_pkg::CNT_W;

  // Synchronised pins: sck, ss_n, mosi, spi_en, tx_en, carrier, data
  logic [6:0]                 pins_s;
  logic [sdi_io_pkg::CLI_W-1:0] cli_s;
  logic                       sck_s;
  logic                       ss_n_s;
  logic                       mosi_s;
  logic                       spi_en_s;
  logic                       tx_en_s;
  logic                       carrier_s;
  logic                       data_s;

  sync_2ff #(
    .WIDTH   (7),
    .RST_VAL (7'h02)
  ) u_pin_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i ({equalizer_data_i, signal_detect_i, tx_enable_i,
               spi_enable_i, mosi_i, ss_n_i, sck_i}),
    .sync_o  (pins_s)
  );

  // Cable length is quasi-static; bits may land a cycle apart
  sync_2ff #(
    .WIDTH   (sdi_io_pkg::CLI_W),
    .RST_VAL (5'h00)
  ) u_cli_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i (cable_length_i),
    .sync_o  (cli_s)
  );

  assign sck_s     = pins_s[0];
  assign ss_n_s    = pins_s[1];
  assign mosi_s    = pins_s[2];
  assign spi_en_s  = pins_s[3];
  assign tx_en_s   = pins_s[4];
  assign carrier_s = pins_s[5];
  assign data_s    = pins_s[6];

  // Serial clock edges, found on the synchronised copy
  logic sck_d_reg;
  logic sck_rise;
  logic sck_fall;
  logic deselect;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_d_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
    end
  end

  assign sck_rise = sck_s && !sck_d_reg;
  assign sck_fall = !sck_s && sck_d_reg;
  // A disabled port behaves as deselected
  assign deselect = ss_n_s || !spi_en_s;

  // Registers
  logic [DW-1:0] general_control_reg;
  logic [DW-1:0] output_driver_adjust_reg;
  logic [DW-1:0] launch_amplitude_tuning_reg;
  logic          equalizer_sleep;

  // Frame engine
  sdi_io_pkg::spi_state_t state_reg;
  sdi_io_pkg::spi_state_t state_next;
  logic [CW-1:0]          bit_cnt_reg;
  logic [DW-1:0]          shift_reg;
  logic [DW-1:0]          shift_next;
  logic [AW-1:0]          addr_reg;
  logic [DW-1:0]          tx_reg;
  logic                   wr_en_reg;
  logic [AW-1:0]          wr_addr_reg;
  logic [DW-1:0]          wr_data_reg;
  logic [AW-1:0]          rd_addr;
  logic [DW-1:0]          rd_data;
  logic                   header_done;
  logic                   frame_done;

  assign shift_next  = {shift_reg[DW-2:0], mosi_s};
  assign rd_addr     = shift_next[AW-1:0];
  assign header_done = sck_rise && (bit_cnt_reg == sdi_io_pkg::LAST_HEADER_BIT);
  assign frame_done  = sck_rise && (bit_cnt_reg == sdi_io_pkg::LAST_FRAME_BIT);

  // Read mux; unmapped addresses read as zero
  always_comb begin
    unique case (rd_addr)
      sdi_io_pkg::ADDR_GENERAL_CONTROL: rd_data = general_control_reg;
      sdi_io_pkg::ADDR_OUTPUT_DRIVER:   rd_data = output_driver_adjust_reg;
      sdi_io_pkg::ADDR_LAUNCH_AMPL:     rd_data = launch_amplitude_tuning_reg;
      sdi_io_pkg::ADDR_CABLE_LENGTH:    rd_data = {cli_s, 3'h0};
      default:                          rd_data = 8'h00;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sdi_io_pkg::SPI_IDLE: begin
        state_next = sdi_io_pkg::SPI_HEADER;
      end
      sdi_io_pkg::SPI_HEADER: begin
        if (header_done) begin
          // Command bit is first on the wire, so after seven shifts it sits at bit 6
          state_next = shift_reg[AW-1] ? sdi_io_pkg::SPI_READ : sdi_io_pkg::SPI_WRITE;
        end
      end
      sdi_io_pkg::SPI_WRITE: begin
        if (frame_done) begin
          state_next = sdi_io_pkg::SPI_WAIT;
        end
      end
      sdi_io_pkg::SPI_READ: begin
        if (sck_fall && bit_cnt_reg == sdi_io_pkg::READ_END_COUNT) begin
          state_next = sdi_io_pkg::SPI_WAIT;
        end
      end
      sdi_io_pkg::SPI_WAIT: begin
        state_next = sdi_io_pkg::SPI_WAIT;
      end
      default: begin
        state_next = sdi_io_pkg::SPI_IDLE;
      end
    endcase
    if (deselect) begin
      state_next = sdi_io_pkg::SPI_IDLE;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= sdi_io_pkg::SPI_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bit counter and input shifter
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
    end else if (state_reg == sdi_io_pkg::SPI_IDLE) begin
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
    end else if (sck_rise && state_reg != sdi_io_pkg::SPI_WAIT) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      shift_reg   <= shift_next;
    end
  end

  // Address latch for writes
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_reg <= '0;
    end else if (header_done && state_reg == sdi_io_pkg::SPI_HEADER) begin
      addr_reg <= rd_addr;
    end
  end

  // Write strobe at the sixteenth rising edge
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      wr_en_reg <= frame_done && !deselect && state_reg == sdi_io_pkg::SPI_WRITE;
      if (frame_done) begin
        wr_addr_reg <= addr_reg;
        wr_data_reg <= shift_next;
      end
    end
  end

  // Read data fetch and shift-out
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_reg    <= '0;
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end else if (deselect) begin
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end else if (state_reg == sdi_io_pkg::SPI_HEADER) begin
      miso_oe_o <= 1'b0;
      if (header_done) begin
        tx_reg <= rd_data;
      end
    end else if (state_reg == sdi_io_pkg::SPI_READ) begin
      if (sck_fall && bit_cnt_reg != sdi_io_pkg::READ_END_COUNT) begin
        miso_o    <= tx_reg[DW-1];
        miso_oe_o <= 1'b1;
        tx_reg    <= {tx_reg[DW-2:0], 1'b0};
      end
    end else if (state_reg == sdi_io_pkg::SPI_WRITE) begin
      miso_oe_o <= 1'b0;
    end
  end

  // Register writes; carrier bit and general control reserved bits are not writable, output driver and launch amplitude take all eight bits, cable length none
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      general_control_reg         <= sdi_io_pkg::GENERAL_CONTROL_RESET;
      output_driver_adjust_reg    <= sdi_io_pkg::OUTPUT_DRIVER_RESET;
      launch_amplitude_tuning_reg <= sdi_io_pkg::LAUNCH_AMPL_RESET;
    end else begin
      general_control_reg[sdi_io_pkg::CARRIER_BIT] <= carrier_s;
      if (wr_en_reg) begin
        unique case (wr_addr_reg)
          sdi_io_pkg::ADDR_GENERAL_CONTROL: begin
            general_control_reg[6:0] <= wr_data_reg[6:0] &
                                        sdi_io_pkg::GENERAL_CONTROL_WMASK[6:0];
          end
          sdi_io_pkg::ADDR_OUTPUT_DRIVER: begin
            output_driver_adjust_reg <= wr_data_reg;
          end
          sdi_io_pkg::ADDR_LAUNCH_AMPL: begin
            launch_amplitude_tuning_reg <= wr_data_reg;
          end
          default: begin
          end
        endcase
      end
    end
  end

  sleep_control #(
    .DELAY_CYCLES (SLEEP_DELAY_CYCLES)
  ) u_sleep (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .mode_i    (general_control_reg[sdi_io_pkg::SLEEP_MSB:sdi_io_pkg::SLEEP_LSB]),
    .carrier_i (carrier_s),
    .sleep_o   (equalizer_sleep)
  );

  // Equalizer outputs and mode pins
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      equalizer_sleep_o     <= 1'b0;
      equalized_out_p_o     <= 1'b0;
      equalized_out_n_o     <= 1'b0;
      carrier_present_n_o   <= 1'b1;
      cable_driver_enable_o <= 1'b0;
    end else begin
      equalizer_sleep_o     <= equalizer_sleep;
      carrier_present_n_o   <= !carrier_s;
      cable_driver_enable_o <= tx_en_s;
      if (equalizer_sleep) begin
        // Powered down wins over mute
        equalized_out_p_o <= 1'b0;
        equalized_out_n_o <= 1'b0;
      end else if (general_control_reg[sdi_io_pkg::MUTE_BIT]) begin
        equalized_out_p_o <= 1'b0;
        equalized_out_n_o <= 1'b0;
      end else begin
        equalized_out_p_o <= data_s;
        equalized_out_n_o <= !data_s;
      end
    end
  end

  // Settings fields
  assign extended_reach_o = general_control_reg[sdi_io_pkg::EXT_REACH_BIT];
  assign output_swing_o   = output_driver_adjust_reg[sdi_io_pkg::SWING_MSB:sdi_io_pkg::SWING_LSB];
  assign output_offset_o  = output_driver_adjust_reg[sdi_io_pkg::OFFSET_MSB:sdi_io_pkg::OFFSET_LSB];
  assign launch_coarse_o  = launch_amplitude_tuning_reg[sdi_io_pkg::COARSE_BIT];
  assign launch_fine_o    = launch_amplitude_tuning_reg[sdi_io_pkg::FINE_MSB:sdi_io_pkg::FINE_LSB];

endmodule : sdi_io_serial_control

// ==== sdi_io_serial_control_props.sv ====
`timescale 1ns/1ps
module sdi_io_serial_control_props #(
  parameter int SLEEP_DELAY_CYCLES = sdi_io_pkg::SLEEP_DELAY_DEFAULT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Serial port
  input wire logic sck_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  // Mode and status
  input wire logic tx_enable_i,
  input wire logic cable_driver_enable_o,
  input wire logic signal_detect_i,
  input wire logic carrier_present_n_o,
  input wire logic equalizer_sleep_o,
  input wire logic equalized_out_p_o,
  input wire logic equalized_out_n_o
);
  logic       sck_q;
  logic [4:0] rise_cnt;
  logic       wr_frame;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) sck_q <= 1'b0;
    else sck_q <= sck_i;
  end

  // Raw pin count runs ahead of the design's synchronised view
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) rise_cnt <= 5'h00;
    else if (ss_n_i) rise_cnt <= 5'h00;
    else if (sck_i && !sck_q) rise_cnt <= rise_cnt + 5'h01;
  end

  // Command bit on the first raw rise marks a write frame
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) wr_frame <= 1'b0;
    else if (ss_n_i) wr_frame <= 1'b0;
    else if (sck_i && !sck_q && rise_cnt == 5'h00) wr_frame <= !mosi_i;
  end

  AST_WRITE_QUIET: assert property (wr_frame |-> !miso_oe_o)
    else $error("miso enabled during a write frame");

  AST_MISO_IDLE: assert property (!miso_oe_o |-> !miso_o)
    else $error("miso high while released");
  AST_OE_DESELECT: assert property (ss_n_i [*6] |-> !miso_oe_o)
    else $error("miso enabled while deselected");
  AST_OE_START: assert property ($rose(miso_oe_o) |-> rise_cnt == 5'h08)
    else $error("miso enabled away from the eighth clock");
  AST_MISO_HOLD: assert property (miso_oe_o && sck_i && !sck_q |=> $stable(miso_o) [*2])
    else $error("miso moved near a rising clock");
  AST_CARRIER_ON: assert property (signal_detect_i [*5] |-> !carrier_present_n_o)
    else $error("carrier flag not low with signal");
  AST_CARRIER_OFF: assert property (!signal_detect_i [*5] |-> carrier_present_n_o)
    else $error("carrier flag not high without signal");
  AST_TX_FOLLOW: assert property ($stable(tx_enable_i) [*5] |-> cable_driver_enable_o == tx_enable_i)
    else $error("driver enable does not follow pin");
  AST_SLEEP_GATES: assert property (equalizer_sleep_o [*3] |-> !equalized_out_p_o && !equalized_out_n_o)
    else $error("outputs active while asleep");
  AST_OUT_COMPL: assert property (equalized_out_p_o |-> !equalized_out_n_o)
    else $error("both equalizer outputs high");
endmodule : sdi_io_serial_control_props

bind sdi_io_serial_control sdi_io_serial_control_props #(
  .SLEEP_DELAY_CYCLES(SLEEP_DELAY_CYCLES)
) u_sdi_io_serial_control_props (
  .clock_i(clock_i), .nrst_i(nrst_i), .sck_i(sck_i), .ss_n_i(ss_n_i), .mosi_i(mosi_i),
  .miso_o(miso_o), .miso_oe_o(miso_oe_o), .tx_enable_i(tx_enable_i),
  .cable_driver_enable_o(cable_driver_enable_o), .signal_detect_i(signal_detect_i),
  .carrier_present_n_o(carrier_present_n_o), .equalizer_sleep_o(equalizer_sleep_o),
  .equalized_out_p_o(equalized_out_p_o), .equalized_out_n_o(equalized_out_n_o)
);

// ==== sdi_io_spi_host.sv ====
`timescale 1ns/1ps
module sdi_io_spi_host (
  // Serial pins
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  localparam int HALF_NS = 32;

  initial begin
    sck_o  = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Clock stands low between frames; a released line toggles so stale bits never pass
  task automatic xfer(input logic [15:0] word, input int nbits, input bit rd, output logic [7:0] rdata);
    rdata = 8'hXX;
    #13 ss_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      if (!rd || i < 8) mosi_o = word[15-i];
      #HALF_NS sck_o = 1'b1;
      if (rd && i >= 8) rdata[15-i] = miso_oe_i ? miso_i : 1'bx;
      // Hold past the device's pin synchroniser before letting go
      #(HALF_NS / 2);
      if (rd && i >= 7) mosi_o = ~mosi_o;
      #(HALF_NS / 2) sck_o = 1'b0;
    end
    #HALF_NS ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #64;
  endtask : xfer
endmodule : sdi_io_spi_host

// ==== sdi_io_serial_control_bench.sv ====
`timescale 1ns/1ps
module sdi_io_serial_control_bench;
  localparam int SLEEP_CYC = 16;
  localparam int LIMIT     = 30000;

  logic       clock_i, nrst_i, spi_enable_i, tx_enable_i, signal_detect_i, eq_data;
  logic       sck, ss_n, mosi, miso, miso_oe, drv_en, car_n, eq_sleep, out_p, out_n, ext_reach, coarse;
  logic [2:0] swing, offset;
  logic [3:0] fine;
  logic [7:0] d;
  int         failures, checks, cycles;

  sdi_io_serial_control #(.SLEEP_DELAY_CYCLES(SLEEP_CYC)) u_sdi_io_serial_control (
    .clock_i(clock_i), .nrst_i(nrst_i), .sck_i(sck), .ss_n_i(ss_n), .mosi_i(mosi),
    .spi_enable_i(spi_enable_i), .miso_o(miso), .miso_oe_o(miso_oe), .tx_enable_i(tx_enable_i),
    .cable_driver_enable_o(drv_en), .signal_detect_i(signal_detect_i), .cable_length_i(5'h13),
    .equalizer_data_i(eq_data), .carrier_present_n_o(car_n), .equalizer_sleep_o(eq_sleep),
    .equalized_out_p_o(out_p), .equalized_out_n_o(out_n), .extended_reach_o(ext_reach),
    .output_swing_o(swing), .output_offset_o(offset), .launch_coarse_o(coarse), .launch_fine_o(fine));

  sdi_io_spi_host u_sdi_io_spi_host (
    .sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] unused;
    u_sdi_io_spi_host.xfer({1'b0, a, v}, 16, 1'b0, unused);
    cyc(2);
  endtask : wr

  task automatic rdr(input logic [6:0] a, output logic [7:0] v);
    u_sdi_io_spi_host.xfer({1'b1, a, 8'h00}, 16, 1'b1, v);
    cyc(2);
  endtask : rdr

  task automatic t_reset();
    logic [6:0] addrs [6] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h7F};
    logic [7:0] exps [6]  = '{8'h88, 8'h64, 8'h00, 8'h98, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rdr(addrs[i], d);
      chk(d, exps[i], "reset read");
    end
    chk({7'h00, eq_sleep}, 8'h00, "sleep at reset");
  endtask : t_reset

  task automatic t_regs();
    tx_enable_i = 1'b0;
    wr(7'h00, 8'h08);
    wr(7'h02, 8'h30);
    rdr(7'h02, d);
    chk(d, 8'h30, "launch reg");
    chk({3'h0, coarse, fine}, 8'h06, "launch fields");
    wr(7'h01, 8'hA5);
    rdr(7'h01, d);
    chk(d, 8'hA5, "driver reg");
    chk({2'h0, swing, offset}, 8'h29, "driver fields");
    wr(7'h03, 8'hFF);
    rdr(7'h03, d);
    chk(d, 8'h98, "length reg");
    // Aborted frame and disabled port must both leave the register alone
    u_sdi_io_spi_host.xfer({1'b0, 7'h02, 8'hC3}, 12, 1'b0, d);
    spi_enable_i = 1'b0;
    wr(7'h02, 8'h55);
    spi_enable_i = 1'b1;
    rdr(7'h02, d);
    chk(d, 8'h30, "launch kept");
  endtask : t_regs

  task automatic t_mute();
    eq_data = 1'b1;
    wr(7'h00, 8'hFF);
    rdr(7'h00, d);
    chk(d, 8'hF8, "control reg");
    chk({7'h00, ext_reach}, 8'h01, "reach");
    chk({6'h00, out_p, out_n}, 8'h00, "muted");
    wr(7'h00, 8'h00);
    cyc(8);
    chk({6'h00, out_p, out_n}, 8'h02, "unmuted high");
    eq_data = 1'b0;
    cyc(8);
    chk({6'h00, out_p, out_n}, 8'h01, "unmuted low");
  endtask : t_mute

  task automatic t_sleep();
    eq_data = 1'b1;
    signal_detect_i = 1'b0;
    cyc(SLEEP_CYC + 40);
    chk({6'h00, eq_sleep, car_n}, 8'h01, "never sleep");
    rdr(7'h00, d);
    chk(d, 8'h00, "carrier bit");
    wr(7'h00, 8'h08);
    cyc(SLEEP_CYC + 12);
    chk({7'h00, eq_sleep}, 8'h01, "auto asleep");
    chk({6'h00, out_p, out_n}, 8'h00, "asleep outputs");
    wr(7'h00, 8'h18);
    cyc(SLEEP_CYC + 12);
    chk({7'h00, eq_sleep}, 8'h01, "reserved code sleeps");
    signal_detect_i = 1'b1;
    cyc(8);
    chk({7'h00, eq_sleep}, 8'h00, "auto wake");
    wr(7'h00, 8'h10);
    tx_enable_i = 1'b1;
    cyc(6);
    chk({6'h00, eq_sleep, drv_en}, 8'h03, "output mode");
    wr(7'h00, 8'h08);
    tx_enable_i = 1'b0;
    cyc(6);
    chk({6'h00, eq_sleep, drv_en}, 8'h00, "loopback input");
    tx_enable_i = 1'b1;
    cyc(6);
    chk({6'h00, eq_sleep, drv_en}, 8'h01, "loopback output");
  endtask : t_sleep

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial begin
    nrst_i = 1'b0;
    spi_enable_i = 1'b1;
    tx_enable_i = 1'b1;
    signal_detect_i = 1'b1;
    eq_data = 1'b0;
    repeat (10) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    cyc(6);
    t_reset();
    t_regs();
    t_mute();
    t_sleep();
    finish_test();
  end
endmodule : sdi_io_serial_control_bench
